// ### design/fcu_pkg.sv
// Purpose: constants and types for the parallel flash command controller
// Assumes: byte-wide flash with 19 address bits, driven from a 125 MHz clock
// Notes: register map is the controller's own, reached over classic Wishbone
// How it works
// - Unlock pair is AAh to 5555h then 55h to 2AAAh.
// - Unlock pair precedes commands; in six-write sequences at cycles 1-2 and 4-5.
// - Reset to read array is F0h, optionally preceded by unlock pair.
// - After reset issued during erase, wait 5 us before any read.
// - Signature setup is unlock pair then 90h to 5555h.
// - Protection query is the only protection check, never during protection procedure.
// - Chip erase: unlock, 80h to 5555h, unlock, 10h to 5555h.
// - Status bits 0, 1, 2 and 4 are reserved and masked by host.
// - Operation finished when two successive reads give same toggle_flag.
package fcu_pkg;
    localparam int CLK_MHZ = 125;
    localparam int ADDR_W = 19;
    // Bus phase counter loads; each phase lasts one clock cycle more than its value (8 ns each)
    localparam logic [3:0] SETUP_CYC = 4'h3;
    localparam logic [3:0] PULSE_CYC = 4'h9;
    localparam logic [3:0] HOLD_CYC = 4'h3;
    localparam int RST_WAIT_US = 5;
    localparam int RST_WAIT_CYC = RST_WAIT_US * CLK_MHZ;
    localparam logic [18:0] UNLOCK_ADDR1 = 19'h05555;
    localparam logic [18:0] UNLOCK_ADDR2 = 19'h02aaa;
    localparam logic [7:0] UNLOCK_DATA1 = 8'haa;
    localparam logic [7:0] UNLOCK_DATA2 = 8'h55;
    localparam logic [7:0] CMD_RESET = 8'hf0;
    localparam logic [7:0] CMD_SIG = 8'h90;
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
    localparam logic [7:0] CMD_CHIP_CONFIRM = 8'h10;
    // Status bit positions
    localparam int BIT_POLL = 7;
    localparam int BIT_TOGGLE = 6;
    localparam int BIT_FAIL = 5;
    localparam int BIT_TIMER = 3;
    localparam logic [7:0] STATUS_MASK = 8'he8;
    // Query addresses
    localparam logic [18:0] SIG_MAKER_ADDR = 19'h00000;
    localparam logic [18:0] SIG_DEVICE_ADDR = 19'h00001;
    localparam logic [18:0] SIG_PROT_ADDR = 19'h00002;
    localparam int BLK_LSB = 16;
    // Wishbone register offsets (byte addresses)
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_ADDR = 4'h4;
    localparam logic [3:0] REG_DATA = 4'h8;
    localparam logic [3:0] REG_STAT = 4'hc;
    // Operation codes written to CTRL[2:0]
    localparam logic [2:0] OP_READ = 3'h1;
    localparam logic [2:0] OP_WRITE = 3'h2;
    localparam logic [2:0] OP_RESET = 3'h3;
    localparam logic [2:0] OP_SIG = 3'h4;
    localparam logic [2:0] OP_PROT = 3'h5;
    localparam logic [2:0] OP_CHIP_ERASE = 3'h6;
    localparam logic [2:0] OP_POLL = 3'h7;

    typedef struct packed {
        logic [18:0] addr;
        logic [7:0] data;
        logic rd;
    } fcu_cycle_t;

    typedef struct packed {
        logic busy;
        logic done_ok;
        logic failed;
        logic erasing;
    } fcu_stat_t;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_SETUP = 5'b00010,
        ST_PULSE = 5'b00100,
        ST_HOLD = 5'b01000,
        ST_WAIT = 5'b10000
    } fcu_state_t;
endpackage

// ### design/fcu_ctrl.sv
// Purpose: host controller that drives the flash command interface through its pins
// Assumes: flash data pins are asynchronous and are synchronised before use
// Notes: one operation at a time; software polls the status register
//
// The Wishbone slave port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module fcu_ctrl
    import fcu_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Flash pins
    output logic [18:0] fl_addr_o,
    output logic [7:0] fl_dq_o,
    output logic fl_dq_oe_o,
    input wire logic [7:0] fl_dq_i,
    output logic fl_ce_n_o,
    output logic fl_oe_n_o,
    output logic fl_we_n_o
);
    fcu_state_t state;
    fcu_cycle_t seq [0:5];
    logic [2:0] seq_len;
    logic [2:0] seq_idx;
    logic [3:0] phase_cnt;
    logic [9:0] wait_cnt;
    logic [2:0] op;
    logic [18:0] user_addr;
    logic [7:0] user_wdata;
    logic [7:0] rdata;
    logic [7:0] last_status;
    logic have_last;
    logic erasing;
    // Remembers that the reset op was issued mid-erase; erasing itself is cleared at its start
    logic reset_in_erase;
    fcu_stat_t stat;
    logic [7:0] dq_meta;
    logic [7:0] dq_sync;
    logic start;

    function automatic fcu_cycle_t wr(input logic [18:0] a, input logic [7:0] d);
        fcu_cycle_t c;
        c.addr = a;
        c.data = d;
        c.rd = 1'b0;
        return c;
    endfunction

    function automatic fcu_cycle_t rd(input logic [18:0] a);
        fcu_cycle_t c;
        c.addr = a;
        c.data = 8'h00;
        c.rd = 1'b1;
        return c;
    endfunction

    assign start = cyc_i && stb_i && we_i && !ack_o && adr_i == REG_CTRL && sel_i[0]
        && state == ST_IDLE && dat_i[2:0] != 3'h0;

    // Two-stage synchroniser for the data pins
    always_ff @(posedge clk_i) begin
        dq_meta <= fl_dq_i;
        dq_sync <= dq_meta;
    end

    // Wishbone: single-cycle ack, reads of registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0;
        end else begin
            ack_o <= cyc_i && stb_i && !ack_o;
            unique case (adr_i)
                REG_ADDR: dat_o <= {13'h0, user_addr};
                REG_DATA: dat_o <= {24'h0, rdata};
                REG_STAT: dat_o <= {20'h0, last_status, stat};
                default: dat_o <= 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            user_addr <= 19'h0;
            user_wdata <= 8'h0;
        end else if (cyc_i && stb_i && we_i && !ack_o) begin
            if (adr_i == REG_ADDR) user_addr <= dat_i[18:0];
            if (adr_i == REG_DATA && sel_i[0]) user_wdata <= dat_i[7:0];
        end
    end

    // Build the pin cycle list for each operation
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            seq_len <= 3'h0;
            op <= 3'h0;
            for (int i = 0; i < 6; i++) begin
                seq[i] <= '0;
            end
        end else if (start) begin
            op <= dat_i[2:0];
            seq[0] <= wr(UNLOCK_ADDR1, UNLOCK_DATA1);
            seq[1] <= wr(UNLOCK_ADDR2, UNLOCK_DATA2);
            unique case (dat_i[2:0])
                OP_READ: begin
                    seq[0] <= rd(user_addr);
                    seq_len <= 3'h1;
                end
                OP_WRITE: begin
                    seq[0] <= wr(user_addr, user_wdata);
                    seq_len <= 3'h1;
                end
                OP_RESET: begin
                    seq[2] <= wr(UNLOCK_ADDR1, CMD_RESET);
                    seq_len <= 3'h3;
                end
                OP_SIG: begin
                    seq[2] <= wr(UNLOCK_ADDR1, CMD_SIG);
                    // low address bit picks maker or device code
                    seq[3] <= rd(user_addr[0] ? SIG_DEVICE_ADDR : SIG_MAKER_ADDR);
                    seq_len <= 3'h4;
                end
                OP_PROT: begin
                    seq[2] <= wr(UNLOCK_ADDR1, CMD_SIG);
                    seq[3] <= rd(SIG_PROT_ADDR | {user_addr[18:16], 16'h0});
                    seq_len <= 3'h4;
                end
                OP_CHIP_ERASE: begin
                    seq[2] <= wr(UNLOCK_ADDR1, CMD_ERASE_SETUP);
                    seq[3] <= wr(UNLOCK_ADDR1, UNLOCK_DATA1);
                    seq[4] <= wr(UNLOCK_ADDR2, UNLOCK_DATA2);
                    seq[5] <= wr(UNLOCK_ADDR1, CMD_CHIP_CONFIRM);
                    seq_len <= 3'h6;
                end
                default: begin
                    seq[0] <= rd(user_addr);
                    seq_len <= 3'h1;
                end
            endcase
        end
    end

    // Pin sequencer: setup, strobe low, hold, then next cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= ST_IDLE;
            seq_idx <= 3'h0;
            phase_cnt <= 4'h0;
            wait_cnt <= 10'h0;
        end else begin
            unique case (state)
                ST_IDLE: if (start) begin
                    state <= ST_SETUP;
                    seq_idx <= 3'h0;
                    phase_cnt <= SETUP_CYC;
                end
                ST_SETUP: if (phase_cnt == 4'h0) begin
                    state <= ST_PULSE;
                    phase_cnt <= PULSE_CYC;
                end else phase_cnt <= phase_cnt - 4'h1;
                ST_PULSE: if (phase_cnt == 4'h0) begin
                    state <= ST_HOLD;
                    phase_cnt <= HOLD_CYC;
                end else phase_cnt <= phase_cnt - 4'h1;
                ST_HOLD: if (phase_cnt != 4'h0) begin
                    phase_cnt <= phase_cnt - 4'h1;
                end else if (seq_idx + 3'h1 < seq_len) begin
                    seq_idx <= seq_idx + 3'h1;
                    state <= ST_SETUP;
                    phase_cnt <= SETUP_CYC;
                end else if (op == OP_RESET && reset_in_erase) begin
                    state <= ST_WAIT;
                    wait_cnt <= 10'(RST_WAIT_CYC);
                end else state <= ST_IDLE;
                ST_WAIT: if (wait_cnt == 10'h0) state <= ST_IDLE;
                    else wait_cnt <= wait_cnt - 10'h1;
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Pins: address held through the whole cycle, strobe only in pulse phase
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fl_addr_o <= 19'h0;
            fl_dq_o <= 8'h0;
            fl_dq_oe_o <= 1'b0;
            fl_ce_n_o <= 1'b1;
            fl_oe_n_o <= 1'b1;
            fl_we_n_o <= 1'b1;
        end else begin
            fl_addr_o <= seq[seq_idx].addr;
            fl_dq_o <= seq[seq_idx].data;
            fl_dq_oe_o <= (state != ST_IDLE && state != ST_WAIT) && !seq[seq_idx].rd;
            fl_ce_n_o <= !(state == ST_PULSE);
            fl_oe_n_o <= !(state == ST_PULSE && seq[seq_idx].rd);
            fl_we_n_o <= !(state == ST_PULSE && !seq[seq_idx].rd);
        end
    end

    // Capture read data at end of pulse; decode erase status
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata <= 8'h0;
            last_status <= 8'h0;
            have_last <= 1'b0;
            erasing <= 1'b0;
            reset_in_erase <= 1'b0;
            stat <= '0;
        end else begin
            stat.busy <= state != ST_IDLE || start;
            stat.erasing <= erasing;
            if (start && dat_i[2:0] == OP_CHIP_ERASE) begin
                erasing <= 1'b1;
                have_last <= 1'b0;
                stat.done_ok <= 1'b0;
                stat.failed <= 1'b0;
            end
            if (start && dat_i[2:0] == OP_RESET) begin
                reset_in_erase <= erasing;
                erasing <= 1'b0;
                stat.failed <= 1'b0;
            end
            if (state == ST_PULSE && phase_cnt == 4'h0 && seq[seq_idx].rd) begin
                rdata <= dq_sync;
                if (op == OP_POLL) begin
                    last_status <= dq_sync & STATUS_MASK;
                    have_last <= 1'b1;
                    // steady toggle on two reads means finished
                    if (erasing && have_last
                        && dq_sync[BIT_TOGGLE] == last_status[BIT_TOGGLE]) begin
                        erasing <= 1'b0;
                        stat.done_ok <= dq_sync[BIT_POLL];
                    // Array data after completion may have bit 5 set; trust it only while busy
                    end else if (erasing && !dq_sync[BIT_POLL] && dq_sync[BIT_FAIL]) begin
                        stat.failed <= 1'b1;
                    end
                end
            end
        end
    end
endmodule
`default_nettype wire

// ### verification/fcu_ctrl_sva.sv
// Purpose: port checks for fcu_ctrl
// Assumes: one clock, synchronous reset
// Notes: key bytes must reach the pins at their own unlock addresses
`timescale 1ns/1ps
`default_nettype none
module fcu_ctrl_sva (
    // Bus
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic ack_o,
    // Flash
    input wire logic [18:0] fl_addr_o,
    input wire logic [7:0] fl_dq_o,
    input wire logic fl_dq_oe_o,
    input wire logic fl_ce_n_o,
    input wire logic fl_oe_n_o,
    input wire logic fl_we_n_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [7:0] prev_dq;
    sequence s_wr;
        $fell(fl_we_n_o);
    endsequence
    sequence s_low;
        !fl_we_n_o [*8];
    endsequence
    // Data of the write before, to see that a command follows a key
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prev_dq <= 8'h00;
        end else if ($rose(fl_we_n_o)) begin
            prev_dq <= fl_dq_o;
        end
    end
    a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack too long");
    a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("no ack");
    a_write_drive: assert property (!fl_we_n_o |-> fl_oe_n_o && !fl_ce_n_o && fl_dq_oe_o)
        else $error("bad write pins");
    a_read_float: assert property (!fl_oe_n_o |-> !fl_dq_oe_o && !fl_ce_n_o)
        else $error("bad read pins");
    a_pulse_len: assert property (s_wr |-> s_low) else $error("short strobe");
    a_hold_pins: assert property (!$past(fl_we_n_o) |-> $stable(fl_addr_o) && $stable(fl_dq_o))
        else $error("pins moved");
    a_key_one: assert property (s_wr ##0 fl_dq_o == 8'haa |-> fl_addr_o == 19'h05555)
        else $error("first key");
    a_key_two: assert property (s_wr ##0 fl_dq_o == 8'h55 |-> fl_addr_o == 19'h02aaa)
        else $error("second key");
    a_cmd_unlocked: assert property (s_wr ##0 fl_dq_o inside {8'h80, 8'h10, 8'h90} |->
        fl_addr_o == 19'h05555 && prev_dq == 8'h55) else $error("command not unlocked");
endmodule
bind fcu_ctrl fcu_ctrl_sva fcu_ctrl_sva_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .ack_o(ack_o), .fl_addr_o(fl_addr_o), .fl_dq_o(fl_dq_o),
    .fl_dq_oe_o(fl_dq_oe_o), .fl_ce_n_o(fl_ce_n_o), .fl_oe_n_o(fl_oe_n_o), .fl_we_n_o(fl_we_n_o));
`default_nettype wire

// ### verification/fcu_flash_model.sv
// Purpose: behavioural flash command interface
// Assumes: 8 stored bytes stand for the array
// Notes: erase lasts ERASE_RD status reads
`timescale 1ns/1ps
`default_nettype none
module fcu_flash_model #(
    parameter int ERASE_RD = 4,
    parameter logic [7:0] MAKER = 8'h3c, // Arbitrary
    parameter logic [7:0] DEVICE = 8'h5a, // Arbitrary
    parameter logic [7:0] PROT = 8'h29
) (
    // Pins
    input wire logic [18:0] addr_i,
    input wire logic [7:0] dq_i,
    input wire logic ce_n_i,
    input wire logic oe_n_i,
    input wire logic we_n_i,
    // Scenario
    input wire logic fail_i,
    output logic [7:0] dq_o
);
    logic [7:0] mem [0:7];
    logic [18:0] la;
    logic [2:0] step = 3'h0;
    logic sig = 1'b0, erasing = 1'b0, failed = 1'b0, tog = 1'b0;
    int left = 0;
    logic wr_act;
    logic rd_act;
    initial begin
        dq_o = 8'h00;
        for (int i = 0; i < 8; i++) mem[i] = 8'h40 + 8'(i);
    end
    // Strobes rise together, so a write ends on whichever of them goes first
    assign wr_act = !ce_n_i && !we_n_i;
    assign rd_act = !ce_n_i && !oe_n_i;
    always @(posedge wr_act) la = addr_i;
    always @(negedge wr_act) begin
        if (dq_i == 8'hf0) begin
            {step, sig, erasing, failed} = '0;
        end else if (!erasing) begin
            case (step)
                3'd0, 3'd3: step = (la == 19'h05555 && dq_i == 8'haa) ? step + 3'd1 : 3'd0;
                3'd1, 3'd4: step = (la == 19'h02aaa && dq_i == 8'h55) ? step + 3'd1 : 3'd0;
                3'd2: begin
                    sig = (la == 19'h05555 && dq_i == 8'h90);
                    step = (la == 19'h05555 && dq_i == 8'h80) ? 3'd3 : 3'd0;
                end
                default: begin
                    erasing = (la == 19'h05555 && dq_i == 8'h10);
                    left = ERASE_RD;
                    step = 3'd0;
                    for (int i = 0; i < 8; i++) if (erasing) mem[i] = 8'h00;
                end
            endcase
        end
    end
    always @(posedge rd_act) begin
        if (erasing) begin
            tog = !tog;
            left = left - 1;
            dq_o = {2'b00, tog, 5'b01101} << 1;
            dq_o[0] = 1'b1;
            if (left == 0) begin
                erasing = 1'b0;
                failed = fail_i;
                for (int i = 0; i < 8; i++) mem[i] = 8'hff;
            end
        end else if (failed) begin
            // A failed erase never completes: poll stays 0 and toggle runs on
            tog = !tog;
            dq_o = {1'b0, tog, 6'b111011};
        end
        else if (sig && addr_i[1] && !addr_i[0] && !addr_i[6]) dq_o = {7'h0, PROT[addr_i[18:16]]};
        else if (sig) dq_o = addr_i[0] ? DEVICE : MAKER;
        else dq_o = mem[addr_i[2:0]];
    end
    // A released bus must not keep the last byte
    always @(negedge rd_act) dq_o = ~dq_o;
endmodule
`default_nettype wire

// ### verification/fcu_ctrl_tb.sv
// Purpose: self-checking bench for fcu_ctrl
// Assumes: flash model on the pins
// Notes: all work goes through Wishbone
`timescale 1ns/1ps
`default_nettype none
module fcu_ctrl_tb
    import fcu_pkg::*;
;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, fail = 1'b0;
    logic [3:0] adr_i = 4'h0, sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0, dat_o, rd, st;
    logic ack_o, dq_oe, ce_n, oe_n, we_n;
    logic [18:0] fa;
    logic [7:0] dq_c, dq_f, dq_w;
    int n_fail = 0, checked = 0, cycles = 0, t0;
    always #4 clk_i = ~clk_i;
    always @(posedge clk_i) cycles++;
    assign dq_w = dq_oe ? dq_c : dq_f;
    fcu_ctrl fcu_ctrl_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .fl_addr_o(fa), .fl_dq_o(dq_c), .fl_dq_oe_o(dq_oe), .fl_dq_i(dq_w), .fl_ce_n_o(ce_n),
        .fl_oe_n_o(oe_n), .fl_we_n_o(we_n));
    fcu_flash_model fcu_flash_model_i (.addr_i(fa), .dq_i(dq_w), .ce_n_i(ce_n), .oe_n_i(oe_n),
        .we_n_i(we_n), .fail_i(fail), .dq_o(dq_f));
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= 4'hf;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic op(input logic [2:0] code, input logic [18:0] a);
        wb(1'b1, REG_ADDR, {13'h0, a});
        wb(1'b1, REG_CTRL, {29'h0, code});
        for (int i = 0; i < 400; i++) begin
            wb(1'b0, REG_STAT, 32'h0);
            if (rd[3] !== 1'b1) break;
        end
        if (rd[3] !== 1'b0) chk("idle", 1'b0, rd[3]);
        st = rd;
    endtask
    task automatic get(input logic [2:0] code, input logic [18:0] a);
        op(code, a);
        wb(1'b0, REG_DATA, 32'h0);
    endtask
    task automatic poke(input logic [18:0] a, input logic [7:0] d);
        wb(1'b1, REG_DATA, {24'h0, d});
        op(OP_WRITE, a);
    endtask
    task automatic till_done;
        for (int i = 0; i < 20 && st[0] === 1'b1; i++) op(OP_POLL, 19'h0);
    endtask
    task automatic end_of_test;
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        #480000;
        n_fail++;
        end_of_test;
    end
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(1'b0, REG_STAT, 32'h0);
        chk("stat", 32'h0, rd);
        wb(1'b0, 4'h2, 32'h0);
        chk("unmapped", 32'h0, rd);
        get(OP_READ, 19'h3);
        chk("array", 8'h43, rd[7:0]);
        get(OP_SIG, 19'h0);
        chk("maker", 8'h3c, rd[7:0]);
        get(OP_SIG, 19'h1);
        chk("device", 8'h5a, rd[7:0]);
        for (int b = 0; b < 8; b++) begin
            get(OP_PROT, {3'(b), 16'h0002});
            chk("protect", (32'h29 >> b) & 32'h1, rd[7:0]);
        end
        op(OP_RESET, 19'h0);
        get(OP_READ, 19'h1);
        chk("after_reset", 8'h41, rd[7:0]);
        $display("test signature done");
        // Erase set-up, then a signature command where the confirm belongs
        poke(19'h05555, 8'haa);
        poke(19'h02aaa, 8'h55);
        poke(19'h05555, 8'h80);
        poke(19'h05555, 8'haa);
        poke(19'h02aaa, 8'h55);
        poke(19'h05555, 8'h90);
        get(OP_READ, 19'h0);
        chk("abort", 8'h40, rd[7:0]);
        $display("test abort done");
        op(OP_CHIP_ERASE, 19'h0);
        get(OP_SIG, 19'h0);
        chk("sig_busy", 8'h48, rd[7:0] & 8'he8);
        op(OP_POLL, 19'h0);
        chk("erasing", 9'h011, {st[11:4], st[0]});
        op(OP_POLL, 19'h0);
        chk("toggle", 8'h48, st[11:4]);
        till_done;
        chk("done", 11'h744, {st[11:4], st[2:0]});
        get(OP_READ, 19'h5);
        chk("erased", 8'hff, rd[7:0]);
        $display("test erase done");
        fail <= 1'b1;
        op(OP_CHIP_ERASE, 19'h0);
        till_done;
        chk("failed", 1'b1, st[1]);
        fail <= 1'b0;
        op(OP_RESET, 19'h0);
        chk("fail_clear", 1'b0, st[1]);
        op(OP_CHIP_ERASE, 19'h0);
        t0 = cycles;
        op(OP_RESET, 19'h0);
        chk("rst_wait", 3'b001, {st[3], st[0], (cycles - t0) > RST_WAIT_CYC});
        $display("test erase_fail done");
        end_of_test;
    end
endmodule
`default_nettype wire
